// ===== rtl/atap_hash.sv
`timescale 1ns/10ps
`default_nettype none

module atap_hash #(
  parameter int AW = 12
) (
  input  wire logic [6:0]    fgid_i,
  input  wire logic [47:0]   mac_i,
  output logic      [AW-1:0] slot_o
);

  // ==========================================================================
  // Fold filter group id and address into a slot number
  logic [59:0] key;
  assign key = {5'h00, fgid_i, mac_i};

  always_comb begin
    slot_o = '0;
    for (int i = 0; i < 60; i++) begin
      slot_o[i % AW] = slot_o[i % AW] ^ key[i];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/atap_pkg.sv
`default_nettype none
package atap_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [15:0] ADDR_INDEX0   = 16'h0410;
  localparam logic [15:0] ADDR_INDEX1   = 16'h0414;
  localparam logic [15:0] ADDR_LU_CTRL  = 16'h0418;
  localparam logic [15:0] ADDR_SM_CTRL  = 16'h041c;
  localparam logic [15:0] ADDR_ENTRY1   = 16'h0420;
  localparam logic [15:0] ADDR_ENTRY2   = 16'h0424;
  localparam logic [15:0] ADDR_ENTRY3   = 16'h0428;
  localparam logic [15:0] ADDR_ENTRY4   = 16'h042c;
  localparam logic [15:0] ADDR_RDY_CLR  = 16'h042f;

  // ==========================================================================
  // Field positions
  localparam int GO_BIT        = 7;
  localparam int READY_BIT     = 6;
  localparam int RDY_OR_END    = 5;
  localparam int DIRECT_BIT    = 2;
  localparam int TSEL_BIT      = 1;
  localparam int SM_OP_BIT     = 0;
  localparam int CNT_LSB       = 16;
  localparam int CNT_W         = 14;
  localparam int FGID_LSB      = 16;
  localparam int FGID_W        = 7;
  localparam int MC_IDX_W      = 6;
  localparam int ST_IDX_W      = 4;
  localparam int TIDX_LSB      = 16;
  localparam int ENTRY_VALID   = 31;

  // ==========================================================================
  // Reset values and masks of writable bits
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [31:0] INDEX0_MASK  = 32'h807f_ffff;
  localparam logic [31:0] LU_CTRL_MASK = 32'h0000_001f;
  localparam logic [31:0] SM_CTRL_MASK = 32'h003f_007f;

  // ==========================================================================
  // Lookup engine operation codes
  typedef enum logic [1:0] {
    LU_NOP    = 2'h0,
    LU_WRITE  = 2'h1,
    LU_READ   = 2'h2,
    LU_SEARCH = 2'h3
  } atap_lu_op_t;

  // Engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_LU_RD = 6'h02,
    ST_SCAN  = 6'h04,
    ST_CHECK = 6'h08,
    ST_HOLD  = 6'h10,
    ST_SM_RD = 6'h20
  } atap_state_t;

endpackage
`default_nettype wire

// ===== rtl/atap_port.sv
// Functional notes
// RL1 - After search ends, a read-only 14-bit field gives the valid entry count
// RL2 - Host sets lookup go bit; device clears it when the operation finishes
// RL3 - Search ready flag rises when next valid entry sits in entry registers
// RL4 - Reading the top byte of the fourth entry register clears ready
// RL5 - Status bit is ready OR search ended, low otherwise
// RL6 - Raw-slot bit selects direct slot addressing, otherwise the hash locates slot
// RL7 - Lookup operation code: 00 none, 01 write, 10 read, 11 search
// RL8 - Index bits 21:16 pick multicast entry; bits 19:16 pick static entry
// RL9 - Host sets static/multicast go bit; device clears it on completion
// RL10 - Table select one means multicast table, zero means static table
// RL11 - Single operation bit one reads, zero writes static/multicast tables
// RL12 - All four entry words serve lookup and static; only word two multicast
// RL13 - Entry word fields are interpreted per the table the operation targets
// RL14 - Hash combines the 7-bit filter group id with the MAC address
// RL15 - Raw-slot mode uses low 12 bits of lower MAC index as slot
// RL16 - Host waits for go to read zero before changing values or restarting
// RL17 - Host reads entry registers ending with the fourth to advance a search
`timescale 1ns/10ps
`default_nettype none

module atap_port #(
  parameter int LU_AW = 12,
  parameter int LU_DW = 128,
  parameter int ST_AW = 4,
  parameter int MC_AW = 6
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o
);

  // ==========================================================================
  // Register storage
  logic [31:0]              index0;
  logic [31:0]              index1;
  logic [4:0]               lu_cfg;
  logic                     lu_go;
  logic                     lu_ready;
  logic [atap_pkg::CNT_W-1:0] valid_count;
  logic [atap_pkg::CNT_W-1:0] run_count;
  logic [31:0]              sm_cfg;
  logic                     sm_go;
  logic [31:0]              entry [0:3];
  logic [LU_AW-1:0]         scan;
  atap_pkg::atap_state_t    state;
  atap_pkg::atap_state_t    next_state;

  // ==========================================================================
  // Byte lane merge
  function automatic logic [31:0] put_byte(input logic [31:0] old, input logic [1:0] lane,
                                           input logic [7:0] b, input logic [31:0] mask);
    logic [31:0] v;
    v = old;
    v[lane*8 +: 8] = b;
    return (v & mask) | (old & ~mask);
  endfunction

  // ==========================================================================
  // Address decode
  wire [15:0] word_addr = {reg_addr_i[15:2], 2'b00};
  wire [1:0]  lane      = reg_addr_i[1:0];
  wire wr_idx0  = reg_wr_i && (word_addr == atap_pkg::ADDR_INDEX0);
  wire wr_idx1  = reg_wr_i && (word_addr == atap_pkg::ADDR_INDEX1);
  wire wr_luc   = reg_wr_i && (word_addr == atap_pkg::ADDR_LU_CTRL);
  wire wr_smc   = reg_wr_i && (word_addr == atap_pkg::ADDR_SM_CTRL);
  wire wr_ent   = reg_wr_i && (word_addr[15:4] == atap_pkg::ADDR_ENTRY1[15:4]);
  wire [1:0] ent_sel = word_addr[3:2];
  wire rd_top4  = reg_rd_i && (reg_addr_i == atap_pkg::ADDR_RDY_CLR);
  wire go_lu_wr = wr_luc && (lane == 2'h0) && reg_wdata_i[atap_pkg::GO_BIT];
  wire go_sm_wr = wr_smc && (lane == 2'h0) && reg_wdata_i[atap_pkg::GO_BIT];

  // ==========================================================================
  // Field views
  wire [1:0]  lu_op    = lu_cfg[1:0];
  wire        direct   = lu_cfg[atap_pkg::DIRECT_BIT];
  wire        sm_mcast = sm_cfg[atap_pkg::TSEL_BIT];
  wire        sm_read  = sm_cfg[atap_pkg::SM_OP_BIT];
  wire [atap_pkg::MC_IDX_W-1:0] mc_idx = sm_cfg[atap_pkg::TIDX_LSB +: atap_pkg::MC_IDX_W]; // RL8
  wire [atap_pkg::ST_IDX_W-1:0] st_idx = sm_cfg[atap_pkg::TIDX_LSB +: atap_pkg::ST_IDX_W]; // RL8
  wire [6:0]  fgid     = index0[atap_pkg::FGID_LSB +: atap_pkg::FGID_W];
  wire [47:0] mac      = {index0[15:0], index1};
  wire        rdy_or_end = lu_ready | ~lu_go; // RL5

  // ==========================================================================
  // Slot selection
  logic [LU_AW-1:0] hash_slot;
  atap_hash #(.AW(LU_AW)) u_hash (
    .fgid_i (fgid),  // RL14
    .mac_i  (mac),
    .slot_o (hash_slot)
  );
  wire [LU_AW-1:0] host_slot = direct ? index1[LU_AW-1:0] : hash_slot; // RL6 RL15

  // ==========================================================================
  // Table memories
  wire [LU_DW-1:0] entry_all = {entry[3], entry[2], entry[1], entry[0]};
  logic [LU_DW-1:0] lu_rdata;
  logic [LU_DW-1:0] st_rdata;
  logic [31:0]      mc_rdata;
  wire idle      = (state == atap_pkg::ST_IDLE);
  wire lu_start  = idle && lu_go;
  wire sm_start  = idle && !lu_go && sm_go;
  wire lu_we     = lu_start && (lu_op == atap_pkg::LU_WRITE); // RL7
  wire st_we     = sm_start && !sm_read && !sm_mcast; // RL10 RL11
  wire mc_we     = sm_start && !sm_read && sm_mcast;  // RL10 RL11
  wire scanning  = (state == atap_pkg::ST_SCAN);
  wire [LU_AW-1:0] lu_addr = scanning ? scan : host_slot;

  atap_ram #(.AW(LU_AW), .DW(LU_DW)) u_lu_ram (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .we_i    (lu_we),
    .addr_i  (lu_addr),
    .wdata_i (entry_all),  // RL12
    .rdata_o (lu_rdata)
  );
  atap_ram #(.AW(ST_AW), .DW(LU_DW)) u_st_ram (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .we_i    (st_we),
    .addr_i  (st_idx[ST_AW-1:0]),
    .wdata_i (entry_all),  // RL12
    .rdata_o (st_rdata)
  );
  atap_ram #(.AW(MC_AW), .DW(32)) u_mc_ram (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .we_i    (mc_we),
    .addr_i  (mc_idx[MC_AW-1:0]),
    .wdata_i (entry[1]),   // RL12
    .rdata_o (mc_rdata)
  );

  // ==========================================================================
  // Engine events
  wire last_slot  = (scan == {LU_AW{1'b1}});
  wire chk        = (state == atap_pkg::ST_CHECK);
  wire hold       = (state == atap_pkg::ST_HOLD);
  wire found      = chk && lu_rdata[atap_pkg::ENTRY_VALID];
  wire advance    = (chk && !found) || (hold && !lu_ready);
  wire scan_end   = advance && last_slot;
  wire lu_done    = (lu_start && (lu_op == atap_pkg::LU_NOP || lu_op == atap_pkg::LU_WRITE))
                  || (state == atap_pkg::ST_LU_RD) || scan_end;
  wire sm_done    = (sm_start && !sm_read) || (state == atap_pkg::ST_SM_RD);
  wire load_lu    = (state == atap_pkg::ST_LU_RD) || found;
  wire load_st    = (state == atap_pkg::ST_SM_RD) && !sm_mcast;
  wire load_mc    = (state == atap_pkg::ST_SM_RD) && sm_mcast;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      atap_pkg::ST_IDLE: begin
        if (lu_start && lu_op == atap_pkg::LU_READ) begin
          next_state = atap_pkg::ST_LU_RD;
        end else if (lu_start && lu_op == atap_pkg::LU_SEARCH) begin
          next_state = atap_pkg::ST_SCAN;
        end else if (sm_start && sm_read) begin
          next_state = atap_pkg::ST_SM_RD;
        end
      end
      atap_pkg::ST_LU_RD: next_state = atap_pkg::ST_IDLE;
      atap_pkg::ST_SM_RD: next_state = atap_pkg::ST_IDLE;
      atap_pkg::ST_SCAN:  next_state = atap_pkg::ST_CHECK;
      atap_pkg::ST_CHECK: begin
        if (found) begin
          next_state = atap_pkg::ST_HOLD;
        end else begin
          next_state = last_slot ? atap_pkg::ST_IDLE : atap_pkg::ST_SCAN;
        end
      end
      atap_pkg::ST_HOLD: begin
        if (!lu_ready) begin
          next_state = last_slot ? atap_pkg::ST_IDLE : atap_pkg::ST_SCAN;
        end
      end
      default: next_state = atap_pkg::ST_IDLE;
    endcase
  end

  // State and scan pointer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= atap_pkg::ST_IDLE;
      scan  <= '0;
    end else begin
      state <= next_state;
      if (lu_start) begin
        scan <= '0;
      end else if (advance && !last_slot) begin
        scan <= scan + 1'b1;
      end
    end
  end

  // Valid entry counting
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_count   <= '0;
      valid_count <= '0;
    end else begin
      if (lu_start) begin
        run_count <= '0;
      end else if (found) begin
        run_count <= run_count + 1'b1;
      end
      if (scan_end) begin
        valid_count <= run_count; // RL1
      end
    end
  end

  // ==========================================================================
  // Index and configuration registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      index0 <= atap_pkg::RST_WORD;
      index1 <= atap_pkg::RST_WORD;
      lu_cfg <= '0;
      sm_cfg <= atap_pkg::RST_WORD;
    end else begin
      if (wr_idx0) index0 <= put_byte(index0, lane, reg_wdata_i, atap_pkg::INDEX0_MASK);
      if (wr_idx1) index1 <= put_byte(index1, lane, reg_wdata_i, 32'hffff_ffff);
      if (wr_luc && lane == 2'h0) lu_cfg <= reg_wdata_i[4:0];
      if (wr_smc) sm_cfg <= put_byte(sm_cfg, lane, reg_wdata_i, atap_pkg::SM_CTRL_MASK);
    end
  end

  // Go bits and search ready flag
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lu_go    <= 1'b0;
      sm_go    <= 1'b0;
      lu_ready <= 1'b0;
    end else begin
      if (go_lu_wr) lu_go <= 1'b1;
      else if (lu_done) lu_go <= 1'b0; // RL2 RL7
      if (go_sm_wr) sm_go <= 1'b1;
      else if (sm_done) sm_go <= 1'b0; // RL9
      if (found) lu_ready <= 1'b1;      // RL3
      else if (rd_top4 || lu_start) lu_ready <= 1'b0; // RL4 RL17
    end
  end

  // ==========================================================================
  // Entry words, loaded by host or by the engine
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 4; i++) entry[i] <= atap_pkg::RST_WORD;
    end else if (load_lu || load_st) begin
      for (int i = 0; i < 4; i++) begin
        entry[i] <= load_lu ? lu_rdata[i*32 +: 32] : st_rdata[i*32 +: 32]; // RL12 RL13
      end
    end else if (load_mc) begin
      entry[1] <= mc_rdata; // RL12 RL13
    end else if (wr_ent) begin
      entry[ent_sel] <= put_byte(entry[ent_sel], lane, reg_wdata_i, 32'hffff_ffff);
    end
  end

  // ==========================================================================
  // Read data path
  wire [31:0] lu_ctrl_word = {2'b00, valid_count, 8'h00, lu_go, lu_ready, rdy_or_end, lu_cfg};
  wire [31:0] sm_ctrl_word = (sm_cfg & ~32'h0000_0080) | {24'h0, sm_go, 7'h00};
  logic [31:0] rd_word;
  always_comb begin
    case (word_addr)
      atap_pkg::ADDR_INDEX0:  rd_word = index0;
      atap_pkg::ADDR_INDEX1:  rd_word = index1;
      atap_pkg::ADDR_LU_CTRL: rd_word = lu_ctrl_word;
      atap_pkg::ADDR_SM_CTRL: rd_word = sm_ctrl_word;
      atap_pkg::ADDR_ENTRY1:  rd_word = entry[0];
      atap_pkg::ADDR_ENTRY2:  rd_word = entry[1];
      atap_pkg::ADDR_ENTRY3:  rd_word = entry[2];
      atap_pkg::ADDR_ENTRY4:  rd_word = entry[3];
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  // Registered read byte
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) reg_rdata_o <= rd_word[lane*8 +: 8];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/atap_ram.sv
`timescale 1ns/10ps
`default_nettype none

module atap_ram #(
  parameter int AW = 12,
  parameter int DW = 128
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_b_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  // ==========================================================================
  // Storage
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Registered read data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule

`default_nettype wire

// ===== test/atap_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================
// Management host issuing byte accesses
module atap_host_model (
  input  wire logic        mclk_i,
  output logic      [15:0] reg_addr_o,
  output logic             reg_wr_o,
  output logic      [7:0]  reg_wdata_o,
  output logic             reg_rd_o,
  input  wire logic [7:0]  reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  // Idle bus at time zero
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // One byte write, strobe held for one edge, data scrambled after
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge mclk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask

  // One byte read, answer taken one cycle after the strobe
  task automatic rd8(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge mclk_i);
    reg_rd_o   = 1'b0;
    ok         = reg_rvalid_i;
    d          = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== test/atap_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ======================
// Register port checker
module atap_port_asserts #(
  parameter int LU_AW = 12,
  parameter int LU_DW = 128,
  parameter int ST_AW = 4,
  parameter int MC_AW = 6
) (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_rvalid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Read strobe at one byte address
  sequence rd_at(logic [15:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  // Control byte write matching a pattern
  sequence go_wr(logic [15:0] a, logic [7:0] m, logic [7:0] v);
    reg_wr_i && reg_addr_i == a && (reg_wdata_i & m) == v;
  endsequence

  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered");
  no_spurious_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("answer without read strobe");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i < 16'h0410 || reg_addr_i > 16'h042f)
                                    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  reserved_ro_a: assert property (reg_rd_i && reg_addr_i inside {16'h0419, 16'h041d, 16'h041f} |=> reg_rdata_o == 8'h00)
    else $error("reserved byte not zero");
  status_mix_a: assert property (rd_at(16'h0418) |=> reg_rdata_o[5] == (reg_rdata_o[6] || !reg_rdata_o[7]))
    else $error("status bit not ready or ended");
  ready_clear_a: assert property (rd_at(16'h042f) ##2 rd_at(16'h0418) |=> !reg_rdata_o[6])
    else $error("ready not cleared by top entry byte");
  lu_go_clear_a: assert property (go_wr(16'h0418, 8'h82, 8'h80) ##2 rd_at(16'h0418) |=> !reg_rdata_o[7])
    else $error("lookup write go not cleared");
  lu_read_a: assert property (go_wr(16'h0418, 8'h83, 8'h82) ##4 rd_at(16'h0418) |=> !reg_rdata_o[7])
    else $error("lookup read go not cleared");
  sm_go_a: assert property (go_wr(16'h041c, 8'h81, 8'h80) ##2 rd_at(16'h041c) |=> !reg_rdata_o[7])
    else $error("static write go not cleared");
  sm_read_a: assert property (go_wr(16'h041c, 8'h81, 8'h81) ##4 rd_at(16'h041c) |=> !reg_rdata_o[7])
    else $error("static read go not cleared");
endmodule

bind atap_port atap_port_asserts #(.LU_AW(LU_AW), .LU_DW(LU_DW), .ST_AW(ST_AW), .MC_AW(MC_AW)) u_asserts (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o));
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// =====================
// Access port testbench
module testbench;
  localparam logic [127:0] ENT_A = 128'h7777_0007_6666_0006_5555_0005_8aaa_000a;
  localparam logic [127:0] ENT_B = 128'h4444_0004_3333_0003_2222_0002_8111_0001;
  logic         mclk_i;
  logic         rst_b_i;
  logic [15:0]  reg_addr;
  logic         reg_wr;
  logic [7:0]   reg_wdata;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid;
  logic [127:0] v;
  int           err_count;
  int           n_tests;

  atap_port #(.LU_AW(4)) u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid));
  atap_host_model u_host (.mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  // Clock at 100 ns period
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Word accesses as four byte lanes, lane 0 first
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      u_host.wr8(a + 16'(i), d[8*i+:8]);
    end
  endtask
  task automatic rd32(input logic [15:0] a, output logic [31:0] d);
    logic ok;
    for (int i = 0; i < 4; i++) begin
      u_host.rd8(a + 16'(i), d[8*i+:8], ok);
      chk(128'(ok), 128'h1, "read answer");
    end
  endtask

  // Entry words, fourth word last so a search can advance
  task automatic put_ent(input logic [127:0] e);
    for (int i = 0; i < 4; i++) begin
      wr32(16'h0420 + 16'(4*i), e[32*i+:32]);
    end
  endtask
  task automatic get_ent(output logic [127:0] e);
    for (int i = 0; i < 4; i++) begin
      rd32(16'h0420 + 16'(4*i), e[32*i+:32]);
    end
  endtask

  // Poll a go bit until it reads zero, bounded
  task automatic wait_go(input logic [15:0] a);
    logic [7:0] b;
    logic       ok;
    b = 8'h80;
    for (int k = 0; k < 60 && b[7] !== 1'b0; k++) begin
      u_host.rd8(a, b, ok);
    end
    if (b[7] !== 1'b0) begin
      err_count++;
      $display("MISMATCH t=%0t go bit stuck", $time);
      end_of_test();
    end
  endtask

  task automatic lu(input logic [31:0] slot, input logic [7:0] op);
    wr32(16'h0414, slot);
    u_host.wr8(16'h0418, op);
    wait_go(16'h0418);
  endtask
  task automatic sm(input logic [31:0] c);
    wr32(16'h041c, {c[31:8], 8'h00});
    u_host.wr8(16'h041c, c[7:0]);
    wait_go(16'h041c);
  endtask

  task automatic t_reset();
    rd32(16'h0418, v[31:0]);
    chk(128'(v[31:0]), 128'h0000_0020, "lookup control at reset");
    wr32(16'h0418, 32'hffff_ff00);
    rd32(16'h0418, v[31:0]);
    chk(128'(v[31:0]), 128'h0000_0020, "lookup read-only bits");
    wr32(16'h041c, 32'hffff_ff7e);
    rd32(16'h041c, v[31:0]);
    chk(128'(v[31:0]), 128'h003f_007e, "static control read-only bits");
    wr32(16'h041c, 32'h0);
    rd32(16'h0430, v[31:0]);
    chk(128'(v[31:0]), 128'h0, "unmapped address");
  endtask

  task automatic t_lookup();
    put_ent(128'h0);
    for (int s = 0; s < 16; s++) begin
      lu(s, 8'h85);
    end
    put_ent(ENT_B);
    lu(5, 8'h85);
    wr32(16'h0410, 32'h0001_0000);
    put_ent(ENT_A);
    lu(0, 8'h81);
    put_ent(128'h0);
    lu(1, 8'h86);
    get_ent(v);
    chk(v, ENT_A, "hashed entry in slot one");
    lu(5, 8'h86);
    get_ent(v);
    chk(v, ENT_B, "direct slot five");
    put_ent(128'h0);
    lu(0, 8'h82);
    get_ent(v);
    chk(v, ENT_A, "hashed read");
    lu(7, 8'h84);
    get_ent(v);
    chk(v, ENT_A, "no operation keeps entries");
  endtask

  task automatic t_search();
    logic [7:0] b;
    logic       ok;
    int         n;
    n = 0;
    u_host.wr8(16'h0418, 8'h83);
    for (int k = 0; k < 300; k++) begin
      u_host.rd8(16'h0418, b, ok);
      if (b[6] === 1'b1) begin
        get_ent(v);
        chk(v, n == 0 ? ENT_A : ENT_B, "search entry");
        n++;
      end else if (b[7] === 1'b0) begin
        break;
      end
    end
    // Search that never ends counts as a mismatch
    if (b[7] !== 1'b0) begin
      err_count++;
      $display("MISMATCH t=%0t search did not end", $time);
      end_of_test();
    end
    chk(128'(n), 128'h2, "entries found");
    rd32(16'h0418, v[31:0]);
    chk(128'(v[31:0]), 128'h0002_0023, "count after search");
  endtask

  task automatic t_static();
    put_ent(ENT_B);
    sm(32'h0003_0080);
    put_ent(128'h0000_0055_0000_0000);
    sm(32'h0023_0082);
    put_ent(128'h0);
    sm(32'h0013_0081);
    get_ent(v);
    chk(v, ENT_B, "static index bits");
    put_ent(~128'h0);
    sm(32'h0023_0083);
    get_ent(v);
    chk(v, {64'hffff_ffff_ffff_ffff, 32'h55, 32'hffff_ffff}, "multicast word two");
  endtask

  // Reset for three cycles, then the scenarios
  initial begin
    err_count = 0;
    n_tests   = 0;
    rst_b_i   = 1'b0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_lookup();
    t_search();
    t_static();
    end_of_test();
  end
endmodule
`default_nettype wire
